// ===== hdl/hbp_host_port.sv
// Power-on reset generator and configurable host bus port
`timescale 1ns/1ps
module hbp_host_port #(
    parameter int POR_CYCLES = hbp_pkg::POR_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       ext_reset_in_n,
    input  wire logic                       host_type_sel_hi,
    input  wire logic                       host_type_sel_lo,
    input  wire logic                       host_select_high,
    input  wire logic                       host_select_low,
    input  wire logic [hbp_pkg::ADDR_W-1:0] host_addr_bus,
    input  wire logic [hbp_pkg::DATA_W-1:0] host_data_in,
    input  wire logic                       host_rw_or_write_strobe,
    input  wire logic                       host_data_or_read_strobe,
    input  wire logic                       wideband_req,
    input  wire logic                       dsp_req,
    output logic      [hbp_pkg::DATA_W-1:0] host_data_out,
    output logic                            host_data_oe,
    output logic                            wideband_fifo_irq,
    output logic                            dsp_side_irq,
    output logic                            por_out_high,
    output logic                            por_out_low,
    output logic                            synth_serial_clock,
    output logic                            synth_latch_enable_0,
    output logic                            synth_latch_enable_1,
    output logic                            synth_latch_enable_2,
    output logic                            synth_serial_out,
    output logic                            symbol_irq_disable
);
    localparam logic [hbp_pkg::POR_CNT_W-1:0] POR_LAST =
        hbp_pkg::POR_CNT_W'(POR_CYCLES - 1);

    // Drive an interrupt request at the polarity the mode asks for
    function automatic logic irq_level(input logic req, input logic act_low);
        irq_level = act_low ? ~req : req;
    endfunction

    hbp_mem_if mem_bus ();

    hbp_pkg::hbp_por_type          por_state_q;
    logic [hbp_pkg::POR_CNT_W-1:0] por_cnt_q;
    logic                          por_high_q;
    logic                          por_low_q;
    logic                          ext_meta_q;
    logic                          ext_rst_q;
    logic                          wr_prev_q;
    logic                          oe_q;
    logic [hbp_pkg::DATA_W-1:0]    dout_q;
    logic                          wb_irq_q;
    logic                          dsp_irq_q;
    logic                          sym_off_q;
    logic                          syn_clk_q;
    logic                          syn_le0_q;
    logic                          syn_le1_q;
    logic                          syn_le2_q;
    logic                          syn_dat_q;

    ////////////////////////////////////////////////////////////////
    // Power-on reset timer, started by the chip-level reset
    // The external reset input never restarts this count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            por_state_q <= hbp_pkg::HBP_POR_HOLD;
            por_cnt_q   <= '0;
            por_high_q  <= 1'b1;
            por_low_q   <= 1'b0;
        end else begin
            case (por_state_q)
                hbp_pkg::HBP_POR_HOLD: begin
                    por_cnt_q <= por_cnt_q + 1'b1;
                    if (por_cnt_q == POR_LAST) begin
                        por_state_q <= hbp_pkg::HBP_POR_RUN;
                        por_high_q  <= 1'b0;
                        por_low_q   <= 1'b1;
                    end
                end
                default: begin
                    por_state_q <= hbp_pkg::HBP_POR_RUN;
                    por_high_q  <= 1'b0;
                    por_low_q   <= 1'b1;
                end
            endcase
        end
    end

    // External reset synchroniser, asserts at once on chip reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_meta_q <= 1'b1;
            ext_rst_q  <= 1'b1;
        end else begin
            ext_meta_q <= ~ext_reset_in_n;
            ext_rst_q  <= ext_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Internal reset and mode decode
    wire       int_rst   = ext_rst_q | por_high_q;
    wire [1:0] host_type = {host_type_sel_hi, host_type_sel_lo};
    wire       mode_sep  = (host_type == hbp_pkg::TYPE_SEP);
    wire       mode_dsl  = (host_type == hbp_pkg::TYPE_DS_LOW);
    wire       mode_dsh  = (host_type == hbp_pkg::TYPE_DS_HIGH);
    wire       selected  = host_select_high & ~host_select_low;
    // Strobe interpretation per mode
    wire       sep_rd    = mode_sep & ~host_data_or_read_strobe;
    wire       sep_wr    = mode_sep & ~host_rw_or_write_strobe;
    wire       ds_act    = (mode_dsl & ~host_data_or_read_strobe)
                         | (mode_dsh & host_data_or_read_strobe);
    wire       rw_rd     = ds_act & host_rw_or_write_strobe;
    wire       rw_wr     = ds_act & ~host_rw_or_write_strobe;
    wire       rd_act    = selected & (sep_rd | rw_rd) & ~int_rst;
    wire       wr_act    = selected & (sep_wr | rw_wr) & ~int_rst;
    // Only the first cycle of a write strobe stores, so a held strobe writes once
    wire       wr_start  = wr_act & ~wr_prev_q;
    wire       irq_low   = mode_dsl | mode_dsh;
    wire       sym_hit   = wr_start & (host_addr_bus == hbp_pkg::SYM_OFF_ADDR);

    // Memory-like register access, one write per strobe
    assign mem_bus.clr     = int_rst;
    assign mem_bus.wr_en   = wr_start;
    assign mem_bus.wr_addr = host_addr_bus;
    assign mem_bus.wr_data = host_data_in;
    assign mem_bus.rd_addr = host_addr_bus;

    hbp_reg_mem u_mem (
        .clk   (clk),
        .reset (reset),
        .bus   (mem_bus)
    );

    ////////////////////////////////////////////////////////////////
    // Data bus drive and write strobe edge tracking
    // Read data lag two edges behind the address: memory register, then pin register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_prev_q <= 1'b0;
            oe_q      <= 1'b0;
            dout_q    <= hbp_pkg::MEM_RESET;
        end else begin
            wr_prev_q <= wr_act;
            oe_q      <= rd_act;
            dout_q    <= mem_bus.rd_data;
        end
    end

    // Interrupt outputs at mode polarity
    // Requests are masked in internal reset; chip reset drives both outputs low, which is the active level in the data strobe modes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_irq_q  <= 1'b0;
            dsp_irq_q <= 1'b0;
        end else begin
            wb_irq_q  <= irq_level(wideband_req & ~int_rst, irq_low);
            dsp_irq_q <= irq_level(dsp_req & ~int_rst, irq_low);
        end
    end

    // Symbol interrupt disable bit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sym_off_q <= hbp_pkg::SYM_OFF_RST;
        end else if (int_rst) begin
            sym_off_q <= hbp_pkg::SYM_OFF_RST;
        end else if (sym_hit) begin
            sym_off_q <= host_data_in[hbp_pkg::SYM_OFF_BIT];
        end
    end

    // Synthesizer pins parked high and idle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            syn_clk_q <= hbp_pkg::SYNTH_IDLE;
            syn_le0_q <= hbp_pkg::SYNTH_IDLE;
            syn_le1_q <= hbp_pkg::SYNTH_IDLE;
            syn_le2_q <= hbp_pkg::SYNTH_IDLE;
            syn_dat_q <= hbp_pkg::SYNTH_IDLE;
        end else begin
            syn_clk_q <= hbp_pkg::SYNTH_IDLE;
            syn_le0_q <= hbp_pkg::SYNTH_IDLE;
            syn_le1_q <= hbp_pkg::SYNTH_IDLE;
            syn_le2_q <= hbp_pkg::SYNTH_IDLE;
            syn_dat_q <= hbp_pkg::SYNTH_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign host_data_out        = dout_q;
    assign host_data_oe         = oe_q;
    assign wideband_fifo_irq    = wb_irq_q;
    assign dsp_side_irq         = dsp_irq_q;
    assign por_out_high         = por_high_q;
    assign por_out_low          = por_low_q;
    assign synth_serial_clock   = syn_clk_q;
    assign synth_latch_enable_0 = syn_le0_q;
    assign synth_latch_enable_1 = syn_le1_q;
    assign synth_latch_enable_2 = syn_le2_q;
    assign synth_serial_out     = syn_dat_q;
    assign symbol_irq_disable   = sym_off_q;
endmodule

// ===== hdl/hbp_pkg.sv
// Constants shared by the host bus port and its register memory
package hbp_pkg;
    localparam int          ADDR_W       = 5;
    localparam int          DATA_W       = 8;
    localparam int          DEPTH        = 32;
    // Power-on reset length in master clock cycles, nominally 10 ms
    localparam int          POR_TIME_MS  = 10;
    localparam int          POR_CYCLES   = 388800;
    localparam int          POR_CNT_W    = 19;
    // Host type select codes {hi, lo}
    localparam logic [1:0]  TYPE_SEP     = 2'h0;
    localparam logic [1:0]  TYPE_DS_HIGH = 2'h1;
    localparam logic [1:0]  TYPE_DS_LOW  = 2'h2;
    localparam logic [1:0]  TYPE_RSVD    = 2'h3;
    // Location of the symbol interrupt disable bit
    localparam logic [4:0]  SYM_OFF_ADDR = 5'h07;
    localparam int          SYM_OFF_BIT  = 0;
    localparam logic        SYM_OFF_RST  = 1'h1;
    localparam logic [7:0]  MEM_RESET    = 8'h00;
    localparam logic        SYNTH_IDLE   = 1'h1;
    // Power-on reset sequencer states
    typedef enum logic [1:0] {
        HBP_POR_HOLD = 2'b01,
        HBP_POR_RUN  = 2'b10
    } hbp_por_type;
endpackage

// ===== hdl/hbp_mem_if.sv
// Carrier between the port logic and its register memory
`timescale 1ns/1ps
interface hbp_mem_if;
    logic                      clr;
    logic                      wr_en;
    logic [hbp_pkg::ADDR_W-1:0] wr_addr;
    logic [hbp_pkg::DATA_W-1:0] wr_data;
    logic [hbp_pkg::ADDR_W-1:0] rd_addr;
    logic [hbp_pkg::DATA_W-1:0] rd_data;
    modport port (output clr, output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem  (input clr, input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface

// ===== hdl/hbp_reg_mem.sv
// Register memory of the host port with registered read data
`timescale 1ns/1ps
module hbp_reg_mem (
    input wire logic clk,
    input wire logic reset,
    hbp_mem_if.mem   bus
);
    logic [hbp_pkg::DATA_W-1:0] mem_q [hbp_pkg::DEPTH];
    logic [hbp_pkg::DATA_W-1:0] rd_q;

    ////////////////////////////////////////////////////////////////
    // Storage, cleared while internal reset is held
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < hbp_pkg::DEPTH; i++) begin
                mem_q[i] <= hbp_pkg::MEM_RESET;
            end
        end else if (bus.clr) begin
            for (int i = 0; i < hbp_pkg::DEPTH; i++) begin
                mem_q[i] <= hbp_pkg::MEM_RESET;
            end
        end else if (bus.wr_en) begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
    end

    // Read data register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_q <= hbp_pkg::MEM_RESET;
        end else begin
            rd_q <= mem_q[bus.rd_addr];
        end
    end

    assign bus.rd_data = rd_q;
endmodule

// ===== tb/hbp_host_port_asserts.sv
// Property checker for the host bus port outputs
`timescale 1ns/1ps
module hbp_host_port_asserts #(
    parameter int POR_CYCLES = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_reset_in_n,
    input wire logic host_type_sel_hi,
    input wire logic host_type_sel_lo,
    input wire logic host_select_high,
    input wire logic host_select_low,
    input wire logic host_rw_or_write_strobe,
    input wire logic host_data_or_read_strobe,
    input wire logic wideband_req,
    input wire logic dsp_req,
    input wire logic host_data_oe,
    input wire logic wideband_fifo_irq,
    input wire logic dsp_side_irq,
    input wire logic por_out_high,
    input wire logic por_out_low,
    input wire logic symbol_irq_disable
);
    // Decoded mode, select, read strobe and expected interrupt levels
    wire logic [1:0] mode = {host_type_sel_hi, host_type_sel_lo};
    wire logic       sel = host_select_high && !host_select_low;
    wire logic       quiet = !por_out_high && ext_reset_in_n;
    wire logic       rd_act = host_rw_or_write_strobe && ((mode == 2'h0) ?
        !host_data_or_read_strobe : (mode != 2'h3 && host_data_or_read_strobe == mode[0]));
    wire logic       wb_exp = wideband_req ^ mode[1] ^ mode[0];
    wire logic       dsp_exp = dsp_req ^ mode[1] ^ mode[0];
    logic [31:0]     cnt_q;
    // Edges since power-up release, saturating at the pulse length
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 32'h0;
        end else if (cnt_q < POR_CYCLES) begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    por_pair_a: assert property (por_out_low == !por_out_high)
        else $error("reset outputs not complementary");
    por_len_a: assert property (por_out_high == (cnt_q < POR_CYCLES))
        else $error("power-on pulse length wrong");
    por_once_a: assert property (!por_out_high |=> !por_out_high)
        else $error("reset output came back");
    por_hold_a: assert property (por_out_high |-> symbol_irq_disable && !host_data_oe)
        else $error("registers active during power-on pulse");
    ext_rst_a: assert property (!ext_reset_in_n [*4] |-> symbol_irq_disable && !host_data_oe)
        else $error("external reset not applied");
    irq_pol_a: assert property (quiet [*5] |->
        wideband_fifo_irq == $past(wb_exp) && dsp_side_irq == $past(dsp_exp))
        else $error("interrupt level wrong for mode");
    rd_oe_a: assert property (ext_reset_in_n [*2] ##1 (sel && quiet && rd_act) [*2]
        |-> host_data_oe)
        else $error("read not answered");
    idle_oe_a: assert property ((!sel || !rd_act) [*2] |-> !host_data_oe)
        else $error("data bus driven without read");
    cover property (sel && rd_act && quiet);
    cover property ($fell(por_out_high));
    cover property ($fell(ext_reset_in_n) && !por_out_high);
endmodule
bind hbp_host_port hbp_host_port_asserts #(.POR_CYCLES(POR_CYCLES)) chk (.*);

// ===== tb/hbp_host_model.sv
// Behavioural host controller on the parallel port
`timescale 1ns/1ps
module hbp_host_model (
    input  wire logic       clk,
    input  wire logic [1:0] mode,
    output logic            host_type_sel_hi,
    output logic            host_type_sel_lo,
    output logic            host_select_high,
    output logic            host_select_low,
    output logic [4:0]      host_addr_bus,
    output logic [7:0]      host_data_in,
    output logic            host_rw_or_write_strobe,
    output logic            host_data_or_read_strobe,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe
);
    logic       act = 1'b0;
    logic       wr = 1'b0;
    logic [1:0] cs = 2'h1;
    logic [4:0] a_q = 5'h00;
    logic [7:0] d_q = 8'hFF;
    // Straps, selects and demultiplexed address and data lines
    assign {host_type_sel_hi, host_type_sel_lo} = mode;
    assign {host_select_high, host_select_low} = cs;
    assign host_addr_bus = a_q;
    assign host_data_in = d_q;
    // Separate strobes in mode 00, direction line plus data strobe otherwise
    assign host_rw_or_write_strobe = (mode == 2'h0) ? !(act && wr) : !wr;
    assign host_data_or_read_strobe = (mode == 2'h0) ? !(act && !wr) : (act ~^ mode[0]);
    // One access; called just after an edge, returns just after an edge
    task automatic access(input logic [1:0] c, input logic w, input logic [4:0] a,
                          input logic [7:0] d, output logic [7:0] q, output logic oe);
        cs = c;
        a_q = a;
        d_q = w ? d : ~d_q;
        wr = w;
        act = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        q = host_data_out;
        oe = host_data_oe;
        @(posedge clk);
        #1;
        act = 1'b0;
        wr = 1'b0;
        cs = 2'h1;
        a_q = ~a;
        d_q = ~d_q;
        @(posedge clk);
        #1;
    endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module testbench;
    localparam int POR = 20;
    logic clk = 1'b0, reset = 1'b1, ext_reset_in_n = 1'b1;
    logic wideband_req = 1'b0, dsp_req = 1'b0;
    logic [1:0] mode = 2'h0;
    logic host_type_sel_hi, host_type_sel_lo, host_select_high, host_select_low;
    logic host_rw_or_write_strobe, host_data_or_read_strobe, host_data_oe;
    logic [4:0] host_addr_bus;
    logic [7:0] host_data_in, host_data_out, q;
    logic wideband_fifo_irq, dsp_side_irq, por_out_high, por_out_low, oe;
    logic synth_serial_clock, synth_latch_enable_0, synth_latch_enable_1;
    logic synth_latch_enable_2, synth_serial_out, symbol_irq_disable;
    logic [31:0] lfsr_q = 32'h000171B6;
    logic [7:0] ref_mem [32];
    int num_errors = 0;
    int n_tests = 0;
    int n = 0;
    always #2.5 clk = ~clk;
    hbp_host_port #(.POR_CYCLES(POR)) dut (.*);
    hbp_host_model host (.*);
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic irq_exp(input logic [1:0] m, input logic req);
        return req ^ m[1] ^ m[0];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        foreach (ref_mem[i]) ref_mem[i] = 8'h00;
        repeat (8) @(posedge clk);
        #1 check({por_out_high, por_out_low, symbol_irq_disable, synth_serial_clock,
            synth_latch_enable_0, synth_latch_enable_1, synth_latch_enable_2,
            synth_serial_out}, 8'hBF);
        reset = 1'b0;
        for (int i = 1; i <= 100 && por_out_high === 1'b1; i++) begin
            @(posedge clk);
            #1 ext_reset_in_n = !(i inside {[3:6]});
            n = i;
        end
        check(8'(n), 8'(POR));
        if (por_out_high !== 1'b0) summarize();
        $display("power-on test done");
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            for (int k = 0; k < 6; k++) begin
                lfsr_q = lfsr(lfsr_q);
                host.access(2'h2, 1'b1, lfsr_q[4:0], lfsr_q[12:5], q, oe);
                if (m != 3) ref_mem[lfsr_q[4:0]] = lfsr_q[12:5];
            end
            for (int c = 0; c < 4; c++)
                if (c != 2) host.access(2'(c), 1'b1, 5'h1F, 8'h5A, q, oe);
            for (int a = 0; a < 32; a++) begin
                host.access(2'h2, 1'b0, 5'(a), 8'h00, q, oe);
                if (m != 3) check(q, ref_mem[a]);
                check({7'h00, oe}, 8'(m != 3));
            end
            repeat (4) begin
                lfsr_q = lfsr(lfsr_q);
                {wideband_req, dsp_req} = lfsr_q[1:0];
                repeat (2) @(posedge clk);
                #1 check({wideband_fifo_irq, dsp_side_irq}, {irq_exp(mode, lfsr_q[1]),
                    irq_exp(mode, lfsr_q[0])});
            end
            $display("mode %0d test done", m);
        end
        mode = 2'h0;
        host.access(2'h2, 1'b1, 5'h07, 8'hFE, q, oe);
        check({7'h00, symbol_irq_disable}, 8'h00);
        ext_reset_in_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 check({por_out_high, symbol_irq_disable}, 8'h01);
        ext_reset_in_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 host.access(2'h2, 1'b0, 5'h07, 8'h00, q, oe);
        check(q, 8'h00);
        $display("external reset test done");
        summarize();
    end
endmodule
